// File: logic/i2c_target_consts.svh
/*
 Register offsets, field positions, reset values and address classes
 for the serial target block. Assumes APB byte addresses, one word each.
*/
// Contract
// - Control word fully readable and writable
// - Status low six bits read-only
// - Full byte moves to holding buffer, pulse
// - Transmit register has a single stage
// - Own address register holds ten bits
// - Narrow mode compares seven low address bits
// - Wide mode first byte 11110 plus A9:A8
// - Wide low byte compared after first match
// - Repeated start in wide mode: first byte only
// - Seven-bit address values classified by range
// - Enabled target idles until start condition
// - Shift eight bits, then compare address
// - Own bits 6:0 versus shift 7:1, bit0 direction
// - Sample data on rising SCL
// - Acknowledge match, flag on ninth falling edge
// - Address leaves holding buffer and full flag
// - Nine-bit reload drives baud generator
// - Status bit shows full wide match
// - Full buffer: no acknowledge, no overwrite, pulse
// - Read direction: acknowledge, hold SCL low
`ifndef I2C_TARGET_CONSTS_SVH
`define I2C_TARGET_CONSTS_SVH

`define RA_RCV 8'h00
`define RA_TRN 8'h04
`define RA_BRG 8'h08
`define RA_CON 8'h0c
`define RA_STAT 8'h10
`define RA_ADD 8'h14

`define CON_EN 15
`define CON_REL 12
`define CON_WIDE 10
`define ST_TBF 0
`define ST_RBF 1
`define ST_RW 2
`define ST_BUSY 3
`define ST_WIDE 4
`define ST_OVF 6
`define ST_RO_BITS 6

`define CON_RST 16'h1000
`define STAT_HI_RST 10'h000
`define ADD_RST 10'h000
`define BRG_RST 9'h000
`define BYTE_RST 8'h00

`define WIDE_PREFIX 5'h1e
`define LAST_BIT 4'h7
`define ACK_BIT 4'h8
`define END_BIT 4'h9
`define CLS_RESV_LO_MIN 7'h01
`define CLS_HS_MIN 7'h04
`define CLS_NORMAL_MIN 7'h08
`define CLS_WIDE_MIN 7'h78
`define CLS_RESV_HI_MIN 7'h7c

`endif

// File: logic/i2c_target_pkg.sv
/*
 Types shared by the serial target block.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none
package i2c_target_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_LOW_ADDR = 4'b0011,
        ST_LOW_ACK = 4'b0100,
        ST_RX = 4'b0101,
        ST_RX_ACK = 4'b0110,
        ST_TX_HOLD = 4'b0111,
        ST_TX = 4'b1000,
        ST_TX_ACK = 4'b1001
    } target_state_e;

    typedef enum logic [2:0] {
        CLS_GENERAL = 3'b000,
        CLS_RESV_LOW = 3'b001,
        CLS_HS_CODE = 3'b010,
        CLS_NORMAL = 3'b011,
        CLS_WIDE_PFX = 3'b100,
        CLS_RESV_HIGH = 3'b101
    } addr_class_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } pad_in_s;

    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } pad_out_s;

endpackage
`default_nettype wire

// File: logic/i2c_target_address_receive.sv
/*
 Serial two-wire target: address match (7 and 10 bit), double-buffered
 receive, single-stage transmit, APB register file, baud generator.
 Assumes SCL/SDA inputs already synchronous to pclk; open-drain pads
 resolved outside (oe high pulls the wire low).
*/
`timescale 1ns/10ps
`default_nettype none
`include "i2c_target_consts.svh"

module i2c_target_address_receive
    import i2c_target_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pad_in_s pad_i,
    output var pad_out_s pad_o,
    output logic target_event_flag,
    output logic baud_tick
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, `RA_RCV) | hit(a, `RA_TRN) | hit(a, `RA_BRG) |
                 hit(a, `RA_CON) | hit(a, `RA_STAT) | hit(a, `RA_ADD);
    endfunction

    function automatic addr_class_e class_of(input logic [6:0] a);
        if (a >= `CLS_RESV_HI_MIN) class_of = CLS_RESV_HIGH;
        else if (a >= `CLS_WIDE_MIN) class_of = CLS_WIDE_PFX;
        else if (a >= `CLS_NORMAL_MIN) class_of = CLS_NORMAL;
        else if (a >= `CLS_HS_MIN) class_of = CLS_HS_CODE;
        else if (a >= `CLS_RESV_LO_MIN) class_of = CLS_RESV_LOW;
        else class_of = CLS_GENERAL;
    endfunction

    target_state_e state_q, state_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic ack_q, ack_d;
    logic sda_drv_q, sda_drv_d;
    logic rw_q, rw_d;
    logic wide_match_q, wide_match_d;
    logic scl_q, sda_q, scl_hold_q;
    logic evt_d, hold_set, tx_take, rx_load, rx_ovf;

    logic [15:0] serial_control_word_q;
    logic [9:0] stat_hi_q;
    logic [9:0] own_target_address_q;
    logic [8:0] bit_rate_reload_q;
    logic [7:0] transmit_holding_reg_q;
    logic [7:0] receive_holding_buffer_q;
    logic tbf_q, receive_buffer_full_q;
    logic [8:0] baud_cnt_q;
    logic [31:0] prdata_q;

    logic serial_module_enable, wide_address_select, clock_release_bit;
    logic scl_rise, scl_fall, start_det, stop_det, last_bit;
    logic [7:0] rx_byte;
    logic [15:0] stat_word;
    logic wr_acc, rd_acc, rd_setup;

    assign serial_module_enable = serial_control_word_q[`CON_EN];
    assign wide_address_select = serial_control_word_q[`CON_WIDE];
    assign clock_release_bit = serial_control_word_q[`CON_REL];

    assign scl_rise = pad_i.scl & ~scl_q;
    assign scl_fall = ~pad_i.scl & scl_q;
    assign start_det = scl_q & pad_i.scl & sda_q & ~pad_i.sda;
    assign stop_det = scl_q & pad_i.scl & ~sda_q & pad_i.sda;
    assign last_bit = scl_rise & (bit_cnt_q == `LAST_BIT);
    assign rx_byte = {shift_q[6:0], pad_i.sda};

    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    // Received data only ever reaches the buffer from the data phase
    assign rx_load = (state_q == ST_RX) & last_bit &
                     ~receive_buffer_full_q;
    assign rx_ovf = (state_q == ST_RX) & last_bit &
                    receive_buffer_full_q;
    assign tx_take = (state_q == ST_TX_HOLD) & clock_release_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= pad_i.scl;
            sda_q <= pad_i.sda;
        end
    end

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        ack_d = ack_q;
        sda_drv_d = sda_drv_q;
        rw_d = rw_q;
        wide_match_d = wide_match_q;
        evt_d = 1'b0;
        hold_set = 1'b0;
        if (!serial_module_enable) begin
            state_d = ST_IDLE;
            sda_drv_d = 1'b0;
            wide_match_d = 1'b0;
        end else if (start_det) begin
            // Repeated start keeps the wide match for a first-byte check
            state_d = ST_ADDR;
            bit_cnt_d = 4'h0;
            sda_drv_d = 1'b0;
        end else if (stop_det) begin
            state_d = ST_IDLE;
            sda_drv_d = 1'b0;
            wide_match_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sda_drv_d = 1'b0;
                end
                ST_ADDR, ST_LOW_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_d = rx_byte;
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    if (last_bit) begin
                        case (state_q)
                            ST_ADDR: begin
                                rw_d = pad_i.sda;
                                state_d = ST_ADDR_ACK;
                                if (wide_address_select) begin
                                    ack_d = (rx_byte[7:3] == `WIDE_PREFIX) &
                                        (class_of(rx_byte[7:1]) ==
                                         CLS_WIDE_PFX) &
                                        (rx_byte[2:1] ==
                                         own_target_address_q[9:8]) &
                                        (~pad_i.sda | wide_match_q);
                                end else begin
                                    ack_d = (rx_byte[7:1] ==
                                        own_target_address_q[6:0]) &
                                        (class_of(own_target_address_q[6:0])
                                         == CLS_NORMAL);
                                end
                            end
                            ST_LOW_ADDR: begin
                                ack_d = (rx_byte ==
                                    own_target_address_q[7:0]);
                                state_d = ST_LOW_ACK;
                            end
                            default: begin
                                ack_d = ~receive_buffer_full_q;
                                state_d = ST_RX_ACK;
                            end
                        endcase
                    end
                end
                ST_ADDR_ACK, ST_LOW_ACK, ST_RX_ACK: begin
                    if (scl_fall && bit_cnt_q == `ACK_BIT) begin
                        bit_cnt_d = `END_BIT;
                        sda_drv_d = ack_q;
                    end else if (scl_fall) begin
                        bit_cnt_d = 4'h0;
                        sda_drv_d = 1'b0;
                        evt_d = ack_q | (state_q == ST_RX_ACK);
                        case (state_q)
                            ST_ADDR_ACK: begin
                                if (!ack_q) begin
                                    state_d = ST_IDLE;
                                end else if (wide_address_select &&
                                             !wide_match_q) begin
                                    state_d = ST_LOW_ADDR;
                                end else if (rw_q) begin
                                    state_d = ST_TX_HOLD;
                                    hold_set = 1'b1;
                                end else begin
                                    state_d = ST_RX;
                                end
                            end
                            ST_LOW_ACK: begin
                                wide_match_d = ack_q;
                                state_d = ack_q ? ST_RX : ST_IDLE;
                            end
                            default: begin
                                state_d = ST_RX;
                            end
                        endcase
                    end
                end
                ST_TX_HOLD: begin
                    if (tx_take) begin
                        // Single stage: the byte leaves the register here
                        shift_d = transmit_holding_reg_q;
                        sda_drv_d = ~transmit_holding_reg_q[7];
                        bit_cnt_d = 4'h0;
                        state_d = ST_TX;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == `ACK_BIT) begin
                        sda_drv_d = 1'b0;
                        state_d = ST_TX_ACK;
                    end else if (scl_fall) begin
                        shift_d = {shift_q[6:0], 1'b0};
                        sda_drv_d = ~shift_q[6];
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_d = ~pad_i.sda;
                    end else if (scl_fall) begin
                        evt_d = 1'b1;
                        bit_cnt_d = 4'h0;
                        hold_set = ack_q;
                        state_d = ack_q ? ST_TX_HOLD : ST_IDLE;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= `BYTE_RST;
            ack_q <= 1'b0;
            sda_drv_q <= 1'b0;
            rw_q <= 1'b0;
            wide_match_q <= 1'b0;
            target_event_flag <= 1'b0;
            scl_hold_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            ack_q <= ack_d;
            sda_drv_q <= sda_drv_d;
            rw_q <= rw_d;
            wide_match_q <= wide_match_d;
            target_event_flag <= evt_d;
            scl_hold_q <= (state_d == ST_TX_HOLD);
        end
    end

    // One driver for the whole pad bundle
    assign pad_o = '{scl_out: 1'b0, scl_oe: scl_hold_q, sda_out: 1'b0,
                     sda_oe: sda_drv_q};

    // Software setting the release wins over the hardware clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_word_q <= `CON_RST;
        end else if (wr_acc && hit(paddr, `RA_CON)) begin
            serial_control_word_q <= pwdata[15:0];
        end else if (hold_set) begin
            serial_control_word_q[`CON_REL] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_target_address_q <= `ADD_RST;
            bit_rate_reload_q <= `BRG_RST;
            transmit_holding_reg_q <= `BYTE_RST;
        end else if (wr_acc) begin
            if (hit(paddr, `RA_ADD)) begin
                own_target_address_q <= pwdata[9:0];
            end
            if (hit(paddr, `RA_BRG)) begin
                bit_rate_reload_q <= pwdata[8:0];
            end
            if (hit(paddr, `RA_TRN)) begin
                transmit_holding_reg_q <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbf_q <= 1'b0;
        end else if (wr_acc && hit(paddr, `RA_TRN)) begin
            tbf_q <= 1'b1;
        end else if (tx_take) begin
            tbf_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_holding_buffer_q <= `BYTE_RST;
            receive_buffer_full_q <= 1'b0;
        end else if (rx_load) begin
            receive_holding_buffer_q <= rx_byte;
            receive_buffer_full_q <= 1'b1;
        end else if (rd_acc && hit(paddr, `RA_RCV)) begin
            receive_buffer_full_q <= 1'b0;
        end
    end

    // Upper status bits are plain storage; overflow set beats a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_hi_q <= `STAT_HI_RST;
        end else begin
            if (wr_acc && hit(paddr, `RA_STAT)) begin
                stat_hi_q <= pwdata[15:`ST_RO_BITS];
            end
            if (rx_ovf) begin
                stat_hi_q[`ST_OVF-`ST_RO_BITS] <= 1'b1;
            end
        end
    end

    always_comb begin
        stat_word = {stat_hi_q, 6'h00};
        stat_word[`ST_TBF] = tbf_q;
        stat_word[`ST_RBF] = receive_buffer_full_q;
        stat_word[`ST_RW] = rw_q;
        stat_word[`ST_BUSY] = (state_q != ST_IDLE);
        stat_word[`ST_WIDE] = wide_match_q;
    end

    // Reload counter; stopped and preloaded while the module is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt_q <= `BRG_RST;
            baud_tick <= 1'b0;
        end else if (!serial_module_enable || baud_cnt_q == 9'h000) begin
            baud_cnt_q <= bit_rate_reload_q;
            baud_tick <= serial_module_enable;
        end else begin
            baud_cnt_q <= baud_cnt_q - 9'h001;
            baud_tick <= 1'b0;
        end
    end

    // Read data captured in the setup cycle so prdata is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= 32'h0000_0000;
            if (hit(paddr, `RA_RCV))
                prdata_q[7:0] <= receive_holding_buffer_q;
            if (hit(paddr, `RA_TRN)) prdata_q[7:0] <= transmit_holding_reg_q;
            if (hit(paddr, `RA_BRG)) prdata_q[8:0] <= bit_rate_reload_q;
            if (hit(paddr, `RA_CON)) prdata_q[15:0] <= serial_control_word_q;
            if (hit(paddr, `RA_STAT)) prdata_q[15:0] <= stat_word;
            if (hit(paddr, `RA_ADD)) prdata_q[9:0] <= own_target_address_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);

endmodule // i2c_target_address_receive
`default_nettype wire

// File: testbench/i2c_ctrl_model.sv
/* Behavioural two-wire bus controller for the target bench.
   Assumes the bench resolves both open-drain lines with pull-ups. */
`timescale 1ns/10ps
`default_nettype none
module i2c_ctrl_model (
    input wire logic pclk,
    input wire logic scl_ln,
    input wire logic sda_ln,
    output logic scl_dl,
    output logic sda_dl
);
    initial begin
        scl_dl = 1'b0;
        sda_dl = 1'b0;
    end
    task automatic hp();
        repeat (4) @(posedge pclk);
    endtask
    // SDA falls while SCL is high
    task automatic start();
        sda_dl <= 1'b1;
        hp();
        scl_dl <= 1'b1;
        hp();
    endtask
    task automatic rstart();
        sda_dl <= 1'b0;
        hp();
        scl_dl <= 1'b0;
        hp();
        start();
    endtask
    task automatic stop();
        sda_dl <= 1'b1;
        hp();
        scl_dl <= 1'b0;
        hp();
        sda_dl <= 1'b0;
        hp();
    endtask
    // MSB first; bit 0 is the ack slot, a 1 there leaves SDA released
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_dl <= ~d[i];
            hp();
            scl_dl <= 1'b0;
            @(posedge pclk);
            // Target may stretch the low phase
            while (scl_ln !== 1'b1) @(posedge pclk);
            hp();
            q[i] = sda_ln;
            scl_dl <= 1'b1;
            hp();
        end
    endtask
endmodule // i2c_ctrl_model
`default_nettype wire

// File: testbench/i2c_target_props.sv
/* Port checker for the serial target: APB answer, pulse shape and pad
   timing against SCL. Bound to the top module below. */
`timescale 1ns/10ps
`default_nettype none
module i2c_target_props
    import i2c_target_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire pad_in_s pad_i,
    input wire pad_out_s pad_o,
    input wire logic target_event_flag,
    input wire logic baud_tick
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_now: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_unmapped_err: assert property (
        psel && penable && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (
        psel && penable && paddr[1:0] == 2'b00 && paddr <= 8'h14 |-> !pslverr)
        else $error("mapped access flagged as error");
    a_event_pulse: assert property (
        target_event_flag |=> !target_event_flag)
        else $error("event flag longer than one cycle");
    a_event_scl_low: assert property (
        target_event_flag |-> !pad_i.scl && !$past(pad_i.scl))
        else $error("event flag outside SCL low");
    a_ack_rise_low: assert property (
        $rose(pad_o.sda_oe) |-> !pad_i.scl)
        else $error("SDA driven while SCL high");
    a_sda_quiet_high: assert property (
        pad_i.scl && $past(pad_i.scl) |-> $stable(pad_o.sda_oe))
        else $error("SDA changed during SCL high");
    a_open_drain: assert property (!pad_o.scl_out && !pad_o.sda_out)
        else $error("pad driven high");
    a_hold_low: assert property ($rose(pad_o.scl_oe) |-> !pad_i.scl)
        else $error("clock hold began while SCL high");
    a_tick_single: assert property (baud_tick |=> !baud_tick)
        else $error("baud tick longer than one cycle");
    c_event: cover property (target_event_flag);
    c_ack: cover property ($rose(pad_o.sda_oe));
    c_hold: cover property ($rose(pad_o.scl_oe));
endmodule // i2c_target_props
bind i2c_target_address_receive i2c_target_props u_props (.pclk, .presetn,
    .psel, .penable, .paddr, .pready, .pslverr, .pad_i, .pad_o,
    .target_event_flag, .baud_tick);
`default_nettype wire

// File: testbench/tb_i2c_target_address_receive.sv
/* Self-checking bench: registers, 7- and 10-bit match, receive, read hold.
   Assumes the controller model and checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
`include "i2c_target_consts.svh"
module tb_i2c_target_address_receive
    import i2c_target_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, d;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'hc310, q[$];
    logic pready, pslverr, target_event_flag, baud_tick, scl_dl, sda_dl;
    logic [8:0] r;
    logic [14:0] tbl[7] = '{15'h0001, 15'h0307, 15'h050b, 15'h7cf9,
        15'h0810, 15'h77ee, 15'h5ab7};
    pad_in_s pad_i;
    pad_out_s pad_o;
    int mismatches = 0, tests_run = 0, ev_n = 0, bt_n = 0, e0;
    assign pad_i = '{scl: ~(scl_dl | pad_o.scl_oe),
                     sda: ~(sda_dl | pad_o.sda_oe)};
    i2c_target_address_receive DUT (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_i,
        .pad_o, .target_event_flag, .baud_tick);
    i2c_ctrl_model ctl (.pclk, .scl_ln(pad_i.scl), .sda_ln(pad_i.sda),
        .scl_dl, .sda_dl);
    initial begin
        forever #25 pclk = ~pclk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    // Expectation is queued before the read is launched
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic tx(input logic [7:0] b, input logic a);
        ctl.xfer({b, 1'b1}, r);
        chk(r[0], a);
    endtask
    task automatic done(input string s);
        $display("test done: %s", s);
    endtask
    task automatic results();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        if (target_event_flag === 1'b1) ev_n++;
        if (baud_tick === 1'b1) bt_n++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk(prdata, q.pop_front());
        end
    end
    initial begin
        repeat (30000) @(posedge pclk);
        mismatches++;
        results();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`RA_CON, 32'h1000);
        rd(`RA_STAT, 32'h0);
        e0 = xs() & 32'h7fff;
        wr(`RA_CON, e0);
        rd(`RA_CON, e0);
        wr(`RA_STAT, 32'hffbf);
        rd(`RA_STAT, 32'hff80);
        wr(`RA_STAT, 32'h0);
        e0 = xs() & 32'h3ff;
        wr(`RA_ADD, e0);
        rd(`RA_ADD, e0);
        e0 = xs() & 32'h1ff;
        wr(`RA_BRG, e0);
        rd(`RA_BRG, e0);
        rd(8'h18, 32'h0);
        wr(`RA_BRG, 32'h3);
        wr(`RA_ADD, 32'h35a);
        wr(`RA_CON, 32'h1000);
        ctl.start();
        tx(8'hb4, 1'b1);
        ctl.stop();
        done("registers and disabled");
        wr(`RA_CON, 32'h9000);
        // Counted between falling edges: no race with the tick flop
        @(negedge pclk);
        e0 = bt_n;
        repeat (40) @(negedge pclk);
        chk(bt_n - e0, 10);
        chk(bt_n > 0, 1'b1);
        @(posedge pclk);
        e0 = ev_n;
        ctl.start();
        tx(8'hb4, 1'b0);
        rd(`RA_STAT, 32'h8);
        rd(`RA_RCV, 32'h0);
        d = 8'(xs());
        tx(d, 1'b0);
        rd(`RA_STAT, 32'ha);
        tx(~d, 1'b1);
        chk(ev_n - e0, 3);
        rd(`RA_STAT, 32'h4a);
        rd(`RA_RCV, {24'h0, d});
        wr(`RA_STAT, 32'h0);
        ctl.stop();
        done("seven bit receive");
        for (int i = 0; i < 7; i++) begin
            wr(`RA_ADD, {25'h0, tbl[i][14:8]});
            e0 = ev_n;
            ctl.start();
            tx({tbl[i][7:1], 1'b0}, tbl[i][0]);
            ctl.stop();
            chk(ev_n - e0, !tbl[i][0]);
        end
        done("address classes");
        wr(`RA_CON, 32'h9400);
        wr(`RA_ADD, 32'h2a5);
        ctl.start();
        tx(8'hf2, 1'b1);
        ctl.stop();
        ctl.start();
        tx(8'hf4, 1'b0);
        tx(8'ha4, 1'b1);
        ctl.stop();
        ctl.start();
        tx(8'hf4, 1'b0);
        tx(8'ha5, 1'b0);
        rd(`RA_STAT, 32'h18);
        d = 8'(xs());
        tx(d, 1'b0);
        rd(`RA_RCV, {24'h0, d});
        ctl.rstart();
        tx(8'hf5, 1'b0);
        chk(pad_o.scl_oe, 1'b1);
        d = 8'(xs());
        wr(`RA_TRN, {24'h0, d});
        rd(`RA_STAT, 32'h1d);
        wr(`RA_CON, 32'h9400);
        rd(`RA_STAT, 32'h1c);
        ctl.xfer({8'hff, 1'b1}, r);
        chk(r[8:1], d);
        ctl.stop();
        done("ten bit");
        results();
    end
endmodule // tb_i2c_target_address_receive
`default_nettype wire
